// ==== logic/standard_timer_pkg.sv ====
// Package for the 16-bit standard timer: register map, field layout,
// reset values and mode codes.
// Assumes an 8-bit register port with one-cycle read latency.
package standard_timer_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_CTRL_ZERO = 3'h0;
    localparam logic [2:0] ADDR_CTRL_ONE = 3'h1;
    localparam logic [2:0] ADDR_COUNT_LO = 3'h2;
    localparam logic [2:0] ADDR_COUNT_HI = 3'h3;
    localparam logic [2:0] ADDR_CMP_A_LO = 3'h4;
    localparam logic [2:0] ADDR_CMP_A_HI = 3'h5;
    localparam logic [2:0] ADDR_CMP_P = 3'h6;
    localparam logic [2:0] ADDR_FLAGS = 3'h7;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RUN_BIT = 3;
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_P_BIT = 1;

    // ------------------------------------------------------------
    // Mode and pin function codes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_CAPTURE = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h3;

    localparam logic [1:0] PIN_NONE = 2'h0;
    localparam logic [1:0] PIN_LOW = 2'h1;
    localparam logic [1:0] PIN_HIGH = 2'h2;
    localparam logic [1:0] PIN_TOGGLE = 2'h3;

    localparam logic [1:0] PWM_FORCE_OFF = 2'h0;
    localparam logic [1:0] PWM_FORCE_ON = 2'h1;
    localparam logic [1:0] PWM_WAVE = 2'h2;
    localparam logic [1:0] PWM_ONE_PULSE = 2'h3;

    localparam logic [1:0] CAP_RISE = 2'h0;
    localparam logic [1:0] CAP_FALL = 2'h1;
    localparam logic [1:0] CAP_BOTH = 2'h2;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] CMP_A_RESET = 16'h0000;
    localparam logic [7:0] CMP_P_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam int TICK_DIV_DEFAULT = 1;

    typedef struct packed {
        logic [1:0] op_mode_sel;
        logic [1:0] pin_func_sel;
        logic out_init_level;
        logic out_invert;
        logic duty_period_swap;
        logic clear_on_match_a;
    } control_reg_one_s;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage : standard_timer_pkg

// ==== logic/standard_timer.sv ====
// Standard timer: 16-bit up counter, comparators A and P, five modes.
// Assumes pins arrive asynchronously; register port is synchronous.
// ------------------------------------------------------------
// What this block does
// - Compare mode: P match or overflow clears
// - Clear-on-A: A match clears, no P flag
// - Compare A zero: overflow, no A flag
// - Compare mode pin moves only on A
// - A match drives pin high, low, toggle
// - Run rising edge loads initial pin level
// - Timer mode counts like compare, no pin
// - Swap 0: P sets period, A duty
// - Swap 1: A sets period, P duty
// - Duty at or above period: always active
// - PWM raises both flags on matches
// - PWM level, enable/force and invert controls
// - Forced PWM pin keeps counting and flags
// - One-pulse starts on run rise or pin
// - A match ends pulse, clears run, flags
// - One-pulse counter zeroed only at start
// - Capture edge latches counter into A
// - Capture mode P match clears counter
// - Capture code 11 disables capture only
// - No short-pulse filter; prompt latch and flag
// - Compare pin codes: none, low, high, toggle
// - Capture edge codes: rise, fall, both, off
// - Compare P is 8 bits vs top byte
module standard_timer #(
    parameter int TICK_DIV = standard_timer_pkg::TICK_DIV_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire standard_timer_pkg::reg_req_s reg_req,
    output logic [7:0] rd_data,
    input wire logic ext_clock_pin,
    input wire logic capture_pin,
    output logic timer_out,
    output logic timer_out_en
);
    import standard_timer_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    control_reg_one_s ctrl_q;
    logic run_q, run_d, run_prev_q;
    logic [15:0] count_q, count_d;
    logic [15:0] cmp_a_q, cmp_a_d;
    logic [7:0] cmp_p_q;
    logic flag_a_q, flag_a_d, flag_p_q, flag_p_d;
    logic level_q, level_d;
    logic [7:0] rd_data_q;
    logic out_q, out_en_q;
    logic [2:0] ext_sync_q, cap_sync_q;
    logic [15:0] div_q;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire wr_ctrl0 = reg_req.wr && reg_req.addr == ADDR_CTRL_ZERO;
    wire wr_ctrl1 = reg_req.wr && reg_req.addr == ADDR_CTRL_ONE;
    wire wr_a_lo = reg_req.wr && reg_req.addr == ADDR_CMP_A_LO;
    wire wr_a_hi = reg_req.wr && reg_req.addr == ADDR_CMP_A_HI;
    wire wr_p = reg_req.wr && reg_req.addr == ADDR_CMP_P;
    wire wr_flags = reg_req.wr && reg_req.addr == ADDR_FLAGS;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    wire m_cmp = ctrl_q.op_mode_sel == MODE_COMPARE;
    wire m_tmr = ctrl_q.op_mode_sel == MODE_TIMER;
    wire m_cap = ctrl_q.op_mode_sel == MODE_CAPTURE;
    wire m_pwm_grp = ctrl_q.op_mode_sel == MODE_PWM;
    wire m_pulse = m_pwm_grp && ctrl_q.pin_func_sel == PWM_ONE_PULSE;
    wire m_pwm = m_pwm_grp && !m_pulse;
    wire cmp_like = m_cmp || m_tmr;

    // ------------------------------------------------------------
    // Timer clock tick
    // ------------------------------------------------------------
    wire tick = div_q == 16'(TICK_DIV - 1);

    // ------------------------------------------------------------
    // Pin edges; third stage only feeds edge detection
    // ------------------------------------------------------------
    wire ext_rise = ext_sync_q[1] && !ext_sync_q[2];
    wire cap_rise = cap_sync_q[1] && !cap_sync_q[2];
    wire cap_fall = !cap_sync_q[1] && cap_sync_q[2];
    logic cap_edge;
    always_comb begin
        case (ctrl_q.pin_func_sel)
            CAP_RISE: cap_edge = cap_rise;
            CAP_FALL: cap_edge = cap_fall;
            CAP_BOTH: cap_edge = cap_rise || cap_fall;
            default: cap_edge = 1'b0;
        endcase
    end
    // Latched in the cycle after the synchronised edge; within three clocks of the pin change
    wire capture = m_cap && run_q && cap_edge;

    // ------------------------------------------------------------
    // Comparators, looking at the count about to be reached
    // ------------------------------------------------------------
    wire run_rise = run_q && !run_prev_q;
    wire step = run_q && !run_rise && tick;
    wire [15:0] count_inc = count_q + 16'h0001;
    wire a_hit = cmp_a_q != CMP_A_RESET && count_inc == cmp_a_q;
    wire p_top = cmp_p_q == CMP_P_RESET ? count_q == COUNT_MAX
                 : count_inc == {cmp_p_q, 8'h00};
    wire match_a = step && a_hit;
    wire match_p = step && p_top;

    // Counter clear source per mode
    logic clr_count, raise_a, raise_p;
    always_comb begin
        clr_count = 1'b0;
        raise_a = 1'b0;
        raise_p = 1'b0;
        if (cmp_like) begin
            if (ctrl_q.clear_on_match_a) begin
                clr_count = match_a;
                raise_a = match_a;
            end else begin
                clr_count = match_p;
                raise_a = match_a;
                raise_p = match_p;
            end
        end else if (m_pwm) begin
            clr_count = ctrl_q.duty_period_swap ? match_a : match_p;
            raise_a = match_a;
            raise_p = match_p;
        end else if (m_pulse) begin
            raise_a = match_a;
        end else begin
            clr_count = match_p;
            raise_p = match_p;
            raise_a = capture;
        end
    end

    // ------------------------------------------------------------
    // PWM duty compare; 17 bits so a zero P means 65536
    // ------------------------------------------------------------
    wire [16:0] p_full = cmp_p_q == CMP_P_RESET ? 17'h10000
                         : {1'b0, cmp_p_q, 8'h00};
    wire [16:0] duty = ctrl_q.duty_period_swap ? p_full
                       : {1'b0, cmp_a_q};
    // Duty beyond the period keeps this true the whole period
    wire pwm_active = {1'b0, count_q} < duty;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        run_d = run_q;
        if (wr_ctrl0) begin
            run_d = reg_req.wdata[RUN_BIT];
        end
        if (m_pulse && ext_rise) begin
            run_d = 1'b1;
        end
        if (m_pulse && match_a) begin
            run_d = 1'b0;
        end
    end

    always_comb begin
        if (run_rise) begin
            count_d = COUNT_RESET;
        end else if (clr_count) begin
            count_d = COUNT_RESET;
        end else if (step) begin
            count_d = count_inc;
        end else begin
            count_d = count_q;
        end
    end

    always_comb begin
        cmp_a_d = cmp_a_q;
        if (wr_a_lo) begin
            cmp_a_d[7:0] = reg_req.wdata;
        end
        if (wr_a_hi) begin
            cmp_a_d[15:8] = reg_req.wdata;
        end
        // Capture beats a software write in the same cycle
        if (capture) begin
            cmp_a_d = count_q;
        end
    end

    // Set beats write-one-to-clear
    always_comb begin
        flag_a_d = flag_a_q;
        flag_p_d = flag_p_q;
        if (wr_flags && reg_req.wdata[FLAG_A_BIT]) begin
            flag_a_d = 1'b0;
        end
        if (wr_flags && reg_req.wdata[FLAG_P_BIT]) begin
            flag_p_d = 1'b0;
        end
        if (raise_a) begin
            flag_a_d = 1'b1;
        end
        if (raise_p) begin
            flag_p_d = 1'b1;
        end
    end

    // Pin level before inversion
    always_comb begin
        level_d = level_q;
        if (run_rise) begin
            level_d = ctrl_q.out_init_level;
        end else if (m_cmp && match_a) begin
            case (ctrl_q.pin_func_sel)
                PIN_LOW: level_d = 1'b0;
                PIN_HIGH: level_d = 1'b1;
                PIN_TOGGLE: level_d = !level_q;
                default: level_d = level_q;
            endcase
        end else if (m_pulse && (match_a || !run_q)) begin
            level_d = !ctrl_q.out_init_level;
        end else if (m_pwm) begin
            case (ctrl_q.pin_func_sel)
                PWM_FORCE_OFF: level_d = !ctrl_q.out_init_level;
                PWM_FORCE_ON: level_d = ctrl_q.out_init_level;
                default: level_d = pwm_active ? ctrl_q.out_init_level
                                   : !ctrl_q.out_init_level;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_req.addr)
            ADDR_CTRL_ZERO: rd_mux = {4'h0, run_q, 3'h0};
            ADDR_CTRL_ONE: rd_mux = ctrl_q;
            ADDR_COUNT_LO: rd_mux = count_q[7:0];
            ADDR_COUNT_HI: rd_mux = count_q[15:8];
            ADDR_CMP_A_LO: rd_mux = cmp_a_q[7:0];
            ADDR_CMP_A_HI: rd_mux = cmp_a_q[15:8];
            ADDR_CMP_P: rd_mux = cmp_p_q;
            default: rd_mux = {6'h00, flag_p_q, flag_a_q};
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= CTRL_RESET;
            cmp_p_q <= CMP_P_RESET;
        end else begin
            if (wr_ctrl1) begin
                ctrl_q <= reg_req.wdata;
            end
            if (wr_p) begin
                cmp_p_q <= reg_req.wdata;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            run_q <= 1'b0;
            run_prev_q <= 1'b0;
            count_q <= COUNT_RESET;
            cmp_a_q <= CMP_A_RESET;
            flag_a_q <= 1'b0;
            flag_p_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            run_q <= run_d;
            run_prev_q <= run_q;
            count_q <= count_d;
            cmp_a_q <= cmp_a_d;
            flag_a_q <= flag_a_d;
            flag_p_q <= flag_p_d;
            level_q <= level_d;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= tick ? 16'h0000 : div_q + 16'h0001;
        end
    end

    // Two stages for metastability, a third for edge history
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ext_sync_q <= 3'h0;
            cap_sync_q <= 3'h0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], ext_clock_pin};
            cap_sync_q <= {cap_sync_q[1:0], capture_pin};
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_q <= 8'h00;
            out_q <= 1'b0;
            out_en_q <= 1'b0;
        end else begin
            rd_data_q <= reg_req.rd ? rd_mux : 8'h00;
            out_q <= level_d ^ ctrl_q.out_invert;
            out_en_q <= m_cmp || m_pwm_grp;
        end
    end

    assign rd_data = rd_data_q;
    assign timer_out = out_q;
    assign timer_out_en = out_en_q;

endmodule : standard_timer

// ==== tb/standard_timer_properties.sv ====
// Port checker for the standard timer, bound to its top module.
// Assumes one tick per clock and mode changes made while stopped.
module standard_timer_properties
    import standard_timer_pkg::*;
#(
    parameter int TICK_DIV = 1
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire standard_timer_pkg::reg_req_s reg_req,
    input wire logic [7:0] rd_data,
    input wire logic timer_out,
    input wire logic timer_out_en
);
    // ------
    // Shadow of control writes
    // ------
    logic [7:0] ctrl_q;
    logic run_q;
    control_reg_one_s cfg;
    wire wr_zero = reg_req.wr && reg_req.addr == ADDR_CTRL_ZERO;
    wire wr_one = reg_req.wr && reg_req.addr == ADDR_CTRL_ONE;
    assign cfg = ctrl_q;
    wire lvl = cfg.out_init_level ^ cfg.out_invert;
    wire in_cmp = cfg.op_mode_sel == MODE_COMPARE;
    wire in_pwm = cfg.op_mode_sel == MODE_PWM;
    // Software view of run only; one-pulse stops are not tracked
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= CTRL_RESET;
            run_q <= 1'b0;
        end else begin
            if (wr_one) ctrl_q <= reg_req.wdata;
            if (wr_zero) run_q <= reg_req.wdata[RUN_BIT];
        end
    end
    // ------
    // Properties
    // ------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence run_start;
        in_cmp && wr_zero && reg_req.wdata[RUN_BIT] && !run_q;
    endsequence
    sequence ctrl_read;
        reg_req.rd && reg_req.addr == ADDR_CTRL_ONE;
    endsequence
    sequence forced(logic [1:0] code);
        (in_pwm && cfg.pin_func_sel == code && run_q) [*6];
    endsequence
    a_rd_idle: assert property (!$past(reg_req.rd) |-> rd_data == 8'h00)
        else $error("read data outside read slot");
    a_ctrl_readback: assert property (ctrl_read |=> rd_data == $past(ctrl_q))
        else $error("control read mismatch");
    a_cmp_pin_on: assert property (in_cmp [*4] |-> timer_out_en)
        else $error("pin not driven in compare mode");
    a_timer_no_pin: assert property (
        (cfg.op_mode_sel == MODE_TIMER) [*3] |-> !timer_out_en)
        else $error("pin driven in timer mode");
    a_pwm_pin_on: assert property (in_pwm [*3] |-> timer_out_en)
        else $error("pin not driven in pwm mode");
    a_run_init: assert property (run_start |-> ##3 timer_out == lvl)
        else $error("initial level missing");
    a_none_hold: assert property (
        (in_cmp && cfg.pin_func_sel == PIN_NONE && run_q) [*5]
        |-> $stable(timer_out))
        else $error("pin moved with no-change code");
    a_force_off: assert property (
        forced(PWM_FORCE_OFF) |-> timer_out == !lvl)
        else $error("forced inactive level wrong");
    a_force_on: assert property (
        forced(PWM_FORCE_ON) |-> timer_out == lvl)
        else $error("forced active level wrong");
endmodule : standard_timer_properties

bind standard_timer standard_timer_properties #(.TICK_DIV(TICK_DIV)) u_props (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_req(reg_req),
    .rd_data(rd_data), .timer_out(timer_out), .timer_out_en(timer_out_en));

// ==== tb/standard_timer_pins.sv ====
// Far-side pin model: trigger and capture sources.
// Assumes one-cycle request strobes from the bench.
module standard_timer_pins #(
    parameter int HOLD = 4
) (
    input wire logic clk_sys,
    input wire logic trig_req,
    input wire logic cap_req,
    output logic ext_clock_pin,
    output logic capture_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int trig_n = 0;
    int cap_n = 0;
    // Pulses stay high for HOLD clocks, long enough for the synchronisers
    always @(posedge clk_sys) begin
        trig_n <= trig_req ? HOLD : trig_n - int'(trig_n != 0);
        cap_n <= cap_req ? HOLD : cap_n - int'(cap_n != 0);
    end
    assign ext_clock_pin = trig_n != 0;
    assign capture_pin = cap_n != 0;
endmodule : standard_timer_pins

// ==== tb/standard_timer_bench.sv ====
// Self-checking bench for the standard timer with its pin model.
// Assumes a tick on every clock (TICK_DIV of 1).
module standard_timer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import standard_timer_pkg::*;
    // ------
    // Signals and tables
    // ------
    localparam logic [7:0] RUN_ON = 8'h01 << RUN_BIT;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    reg_req_s reg_req = '0;
    logic [7:0] rd_data;
    logic ext_clock_pin, capture_pin, timer_out, timer_out_en;
    logic trig_req = 1'b0;
    logic cap_req = 1'b0;
    logic rd_pend = 1'b0;
    logic [15:0] e;
    // Monitor keeps its own copy; the main sequence reuses e across edges
    logic [15:0] ex;
    logic [15:0] exp_q[$];
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;
    int seed = 32'h9F6EC297;
    logic [2:0] rw_a[5] = '{ADDR_CMP_A_LO, ADDR_CMP_A_HI, ADDR_CMP_P,
        ADDR_COUNT_LO, ADDR_CTRL_ONE};
    logic [7:0] fl_c[3] = '{8'h00, 8'h01, 8'hC0};
    logic [7:0] fl_e[3] = '{8'h02, 8'h01, 8'h02};
    logic [7:0] pw_c[6] = '{8'hA8, 8'hAC, 8'hA8, 8'h88, 8'h98, 8'hAA};
    logic [15:0] pw_a[6] = '{16'h0040, 16'h0040, 16'hFFFF, 16'h0040,
        16'h0040, 16'h0200};
    logic [15:0] pw_e[6] = '{16'h0080, 16'h0180, 16'h0200, 16'h0000,
        16'h0200, 16'h0100};
    always #10 clk_sys = ~clk_sys;
    standard_timer #(.TICK_DIV(1)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .reg_req(reg_req), .rd_data(rd_data), .ext_clock_pin(ext_clock_pin),
        .capture_pin(capture_pin), .timer_out(timer_out),
        .timer_out_en(timer_out_en));
    standard_timer_pins pins (.clk_sys(clk_sys), .trig_req(trig_req),
        .cap_req(cap_req), .ext_clock_pin(ext_clock_pin),
        .capture_pin(capture_pin));
    // ------
    // Tasks
    // ------
    task automatic chk(input logic [15:0] got, input logic [15:0] want,
        input string what);
        n_tests++;
        if (got !== want) begin
            err_count++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask : chk
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_req.addr <= a;
        reg_req.wdata <= d;
        reg_req.wr <= 1'b1;
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
        // Idle edge so the next call never re-raises the strobe at once
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] m,
        input logic [7:0] d);
        exp_q.push_back({m, d});
        reg_req.addr <= a;
        reg_req.rd <= 1'b1;
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
        @(posedge clk_sys);
    endtask : rd
    task automatic seta(input logic [15:0] a);
        wr(ADDR_CMP_A_LO, a[7:0]);
        wr(ADDR_CMP_A_HI, a[15:8]);
    endtask : seta
    // Mode is changed only while stopped; flags cleared before start
    task automatic go(input logic [7:0] c);
        wr(ADDR_CTRL_ZERO, 8'h00);
        wr(ADDR_CTRL_ONE, c);
        wr(ADDR_FLAGS, 8'h03);
        wr(ADDR_CTRL_ZERO, RUN_ON);
    endtask : go
    task automatic highs(input int cycles);
        n = 0;
        repeat (cycles) begin
            @(posedge clk_sys);
            n += int'(timer_out === 1'b1);
        end
    endtask : highs
    task automatic pulse(input logic on_cap);
        trig_req <= !on_cap;
        cap_req <= on_cap;
        @(posedge clk_sys);
        trig_req <= 1'b0;
        cap_req <= 1'b0;
    endtask : pulse
    // ------
    // Read monitor and timeout
    // ------
    always @(posedge clk_sys) begin
        if (rd_pend) begin
            ex = exp_q.pop_front();
            chk(16'(rd_data & ex[15:8]), 16'(ex[7:0]), "read data");
        end
        rd_pend <= reg_req.rd;
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            $display("Error at %0t: timeout", $time);
            conclude();
        end
    end
    // ------
    // Main sequence
    // ------
    initial begin
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        rd(ADDR_CTRL_ONE, 8'hFF, CTRL_RESET);
        rd(ADDR_CMP_A_HI, 8'hFF, CMP_A_RESET[15:8]);
        rd(ADDR_CMP_P, 8'hFF, CMP_P_RESET);
        foreach (rw_a[i]) begin
            e = 16'($random(seed));
            wr(rw_a[i], e[7:0]);
            rd(rw_a[i], 8'hFF, rw_a[i] == ADDR_COUNT_LO ? 8'h00 : e[7:0]);
        end
        $display("test registers finished");
        seta(16'h0003);
        for (int k = 0; k < 4; k++) begin
            go({MODE_COMPARE, k[1:0], 4'h9});
            repeat (3) @(posedge clk_sys);
            chk(timer_out, 1'b1, "initial level");
            repeat (3) @(posedge clk_sys);
            chk(timer_out, !k[0], "level after match");
        end
        $display("test compare pin finished");
        seta(16'h0300);
        wr(ADDR_CMP_P, 8'h01);
        foreach (fl_c[i]) begin
            go(fl_c[i]);
            repeat (1000) @(posedge clk_sys);
            rd(ADDR_FLAGS, 8'h03, fl_e[i]);
        end
        $display("test clear flags finished");
        foreach (pw_c[i]) begin
            seta(pw_a[i]);
            go(pw_c[i]);
            repeat (20) @(posedge clk_sys);
            highs(512);
            chk(16'(n), pw_e[i], "pwm high time");
        end
        rd(ADDR_FLAGS, 8'h03, 8'h03);
        $display("test pwm finished");
        seta(16'h0014);
        go(8'hB8);
        wr(ADDR_CTRL_ZERO, 8'h00);
        pulse(1'b0);
        highs(60);
        chk(16'(n), 16'd20, "pulse width");
        rd(ADDR_CTRL_ZERO, RUN_ON, 8'h00);
        rd(ADDR_FLAGS, 8'h01, 8'h01);
        $display("test one pulse finished");
        wr(ADDR_CMP_P, 8'h00);
        for (int k = 0; k < 4; k++) begin
            seta(16'hFFFF);
            go({MODE_CAPTURE, k[1:0], 4'h0});
            repeat (5) @(posedge clk_sys);
            pulse(1'b1);
            repeat (15) @(posedge clk_sys);
            rd(ADDR_CMP_A_HI, 8'hFF, k == 3 ? 8'hFF : 8'h00);
            rd(ADDR_FLAGS, 8'h01, {7'h00, k != 3});
        end
        $display("test capture finished");
        repeat (3) @(posedge clk_sys);
        conclude();
    end
endmodule : standard_timer_bench
